// File: core/cbs_pkg.sv
// Purpose: Constants, register map and decode helpers for the charger
//          battery and switch configuration slice.
// Assumes: APB word access, pclk at 200 MHz, presetn is the core reset.
// Notes:   Byte address of a register is four times its index.
package cbs_pkg;

	// Register indices and byte addresses
	localparam logic [5:0] IDX_RESTART = 6'h0D;
	localparam logic [5:0] IDX_BATT    = 6'h0F;
	localparam logic [5:0] IDX_SWCFG   = 6'h11;
	localparam logic [5:0] IDX_CTRL    = 6'h20;
	localparam logic [5:0] IDX_STAT    = 6'h21;
	localparam logic [7:0] ADDR_RESTART = {IDX_RESTART, 2'h0};
	localparam logic [7:0] ADDR_BATT    = {IDX_BATT, 2'h0};
	localparam logic [7:0] ADDR_SWCFG   = {IDX_SWCFG, 2'h0};
	localparam logic [7:0] ADDR_CTRL    = {IDX_CTRL, 2'h0};
	localparam logic [7:0] ADDR_STAT    = {IDX_STAT, 2'h0};

	// Field positions
	localparam int CV_LSB      = 0;
	localparam int VSYS_LSB    = 6;
	localparam int WDCLR_LSB   = 0;
	localparam int WDOFF_BIT   = 2;
	localparam int KEEPON_BIT  = 3;
	localparam int WDPER_BIT   = 6;
	localparam int RESTART_LSB = 0;
	localparam int WDEN_BIT    = 0;
	localparam int WDFLT_BIT   = 1;
	localparam int REARM_BIT   = 2;

	// Reset values and special codes
	localparam logic [5:0] CV_RST      = 6'h2B;
	localparam logic [1:0] VSYS_RST    = 2'h0;
	localparam logic [1:0] RESTART_RST = 2'h1;
	localparam logic [1:0] WDCLR_KICK  = 2'h1;
	localparam logic [1:0] RESTART_OFF = 2'h3;

	// Voltage codes and figures in millivolts
	localparam logic [5:0]  CV_FLOOR_CODE = 6'h08;
	localparam logic [5:0]  CV_SAT_CODE   = 6'h37;
	localparam logic [12:0] CV_FLOOR_MV   = 13'hDAC;
	localparam logic [12:0] CV_STEP_MV    = 13'h014;
	localparam logic [12:0] CV_MAX_MV     = 13'h1158;
	localparam logic [12:0] VSYS_LOW_MV   = 13'hDAC;
	localparam logic [12:0] VSYS_MID_MV   = 13'hE74;
	localparam logic [12:0] VSYS_HIGH_MV  = 13'h10CC;
	localparam logic [12:0] DROP_100_MV   = 13'h064;
	localparam logic [12:0] DROP_150_MV   = 13'h096;
	localparam logic [12:0] DROP_200_MV   = 13'h0C8;

	// Timing
	localparam longint unsigned CLK_HZ        = 200_000_000;
	localparam longint unsigned OC_PERSIST_MS = 16;
	localparam longint unsigned WD_LONG_S     = 80;
	localparam longint unsigned WD_SHORT_S    = 32;
	localparam logic [21:0] OC_PERSIST_CYC = 22'(OC_PERSIST_MS * CLK_HZ / 1000);
	localparam logic [34:0] WD_LONG_CYC    = 35'(WD_LONG_S * CLK_HZ);
	localparam logic [34:0] WD_SHORT_CYC   = 35'(WD_SHORT_S * CLK_HZ);

	// Termination code to millivolts
	function automatic logic [12:0] cbs_cv_mv(input logic [5:0] code);
		if (code <= CV_FLOOR_CODE)
			return CV_FLOOR_MV;
		if (code >= CV_SAT_CODE)
			return CV_MAX_MV;
		return 13'(CV_FLOOR_MV + CV_STEP_MV * 13'(code - CV_FLOOR_CODE));
	endfunction : cbs_cv_mv

	// Minimum system voltage; the reserved code falls back to the lowest level
	function automatic logic [12:0] cbs_vsys_mv(input logic [1:0] sel);
		case (sel)
			2'h1:    return VSYS_MID_MV;
			2'h2:    return VSYS_HIGH_MV;
			default: return VSYS_LOW_MV;
		endcase
	endfunction : cbs_vsys_mv

	// Restart drop below termination; zero when restart is off
	function automatic logic [12:0] cbs_drop_mv(input logic [1:0] code);
		case (code)
			2'h0:    return DROP_100_MV;
			2'h1:    return DROP_150_MV;
			2'h2:    return DROP_200_MV;
			default: return 13'h000;
		endcase
	endfunction : cbs_drop_mv

endpackage : cbs_pkg

// File: core/cbs_ocflt.sv
// Purpose: Persistence filter on the synchronised overcurrent level.
// Assumes: oc_level already sits in the pclk domain.
// Notes:   tripped rises after LIMIT continuous high cycles.
`timescale 1ns/100ps
module cbs_ocflt #(
	parameter logic [21:0] LIMIT = cbs_pkg::OC_PERSIST_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic oc_level,
	output logic      tripped
);
	import cbs_pkg::*;

	typedef struct packed {
		logic [21:0] cnt;
		logic        tripped;
	} cbs_flt_s;

	cbs_flt_s st_r;
	cbs_flt_s st_nxt;

	// A dropout restarts the count, so only a continuous condition trips
	always_comb
	begin
		st_nxt = st_r;
		if (!oc_level)
		begin
			st_nxt = '0;
		end
		else if (st_r.cnt >= 22'(LIMIT - 22'h1))
			st_nxt.tripped = 1'b1;
		else
			st_nxt.cnt = 22'(st_r.cnt + 22'h1);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tripped = st_r.tripped;

	dropout_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
		!oc_level |=> (st_r.cnt == 22'h0) && !tripped)
		else $error("overcurrent count kept after dropout");

	full_count_trips_a: assert property (@(posedge pclk) disable iff (!presetn)
		oc_level && (st_r.cnt == 22'(LIMIT - 22'h1)) |=> tripped)
		else $error("overcurrent did not trip at full count");

endmodule : cbs_ocflt

// File: core/cbs_wdog.sv
// Purpose: Watchdog timer with two selectable periods.
// Assumes: restart is a one-cycle pulse from the register file.
// Notes:   expired holds until restart or disable; expiry beats a same-cycle restart.
`timescale 1ns/100ps
module cbs_wdog #(
	parameter logic [34:0] LONG_CYC  = cbs_pkg::WD_LONG_CYC,
	parameter logic [34:0] SHORT_CYC = cbs_pkg::WD_SHORT_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic enable,
	input  wire logic period_sel,
	input  wire logic restart,
	output logic      expired
);
	import cbs_pkg::*;

	typedef struct packed {
		logic [34:0] cnt;
		logic        expired;
	} cbs_wd_s;

	cbs_wd_s     st_r;
	cbs_wd_s     st_nxt;
	logic [34:0] limit;
	logic        exp_now;

	// Period select: clear is the long period
	assign limit   = period_sel ? SHORT_CYC : LONG_CYC;
	assign exp_now = enable && !st_r.expired && (st_r.cnt >= 35'(limit - 35'h1));

	// Count, expire, restart
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.expired = exp_now || (st_r.expired && enable && !restart);
		if (!enable || restart || st_r.expired || exp_now)
			st_nxt.cnt = 35'h0;
		else
			st_nxt.cnt = 35'(st_r.cnt + 35'h1);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign expired = st_r.expired;

	// A shortened period may find the count beyond it for one edge, then expiry zeroes it
	count_in_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		$stable(period_sel) |-> st_r.cnt < limit)
		else $error("watchdog count beyond selected period");

	restart_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
		enable && restart && !exp_now |=> !expired && (st_r.cnt == 35'h0))
		else $error("watchdog restart did not clear the timer");

endmodule : cbs_wdog

// File: core/cbs_top.sv
// Purpose: APB register slice for charge voltage, system minimum voltage
//          and battery isolation switch control.
// Assumes: batt_overcurrent is asynchronous; presetn is the core reset.
// Notes:   Every access takes one wait state; unmapped addresses answer pslverr.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module cbs_top #(
	parameter logic [21:0] OC_PERSIST_CYCLES = cbs_pkg::OC_PERSIST_CYC,
	parameter logic [34:0] WD_LONG_CYCLES    = cbs_pkg::WD_LONG_CYC,
	parameter logic [34:0] WD_SHORT_CYCLES   = cbs_pkg::WD_SHORT_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        batt_overcurrent,
	output logic [12:0]      charge_voltage_mv,
	output logic [12:0]      restart_threshold_mv,
	output logic             restart_enable,
	output logic [1:0]       system_min_voltage_sel,
	output logic [12:0]      system_min_voltage_mv,
	output logic             battery_isolation_switch,
	output logic             watchdog_expired
);
	import cbs_pkg::*;

	typedef struct packed {
		logic        oc_s1;
		logic        oc_s2;
		logic [5:0]  cv;
		logic [1:0]  vsys;
		logic [1:0]  wdclr;
		logic        wdoff;
		logic        keepon;
		logic        wdper;
		logic [1:0]  restart;
		logic        wden;
		logic        wdflt;
		logic        wd_clear;
		logic        oc_lat;
		logic        wd_lat;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [12:0] cv_mv;
		logic [12:0] rst_mv;
		logic [12:0] vsys_mv;
		logic        rst_en;
		logic        sw_on;
	} cbs_top_s;

	// Defaults that the core reset restores
	localparam cbs_top_s TOP_RST = '{
		cv:      CV_RST,
		vsys:    VSYS_RST,
		restart: RESTART_RST,
		cv_mv:   cbs_cv_mv(CV_RST),
		rst_mv:  13'(cbs_cv_mv(CV_RST) - cbs_drop_mv(RESTART_RST)),
		vsys_mv: cbs_vsys_mv(VSYS_RST),
		rst_en:  1'b1,
		sw_on:   1'b1,
		default: '0
	};

	cbs_top_s    st_r;
	cbs_top_s    st_nxt;
	logic        wr_done;
	logic        rd_hit;
	logic [31:0] rd_word;
	logic        rearm;
	logic        oc_tripped;
	logic        wd_expired;

	// A write lands only at the edge that completes the access phase
	assign wr_done = psel && penable && st_r.pready && pwrite;

	// Read decode from the current register state
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (paddr)
			ADDR_BATT:
			begin
				rd_word[CV_LSB +: 6]   = st_r.cv;
				rd_word[VSYS_LSB +: 2] = st_r.vsys;
			end
			ADDR_SWCFG:
			begin
				rd_word[WDCLR_LSB +: 2] = st_r.wdclr;
				rd_word[WDOFF_BIT]      = st_r.wdoff;
				rd_word[KEEPON_BIT]     = st_r.keepon;
				rd_word[WDPER_BIT]      = st_r.wdper;
			end
			ADDR_RESTART:
				rd_word[RESTART_LSB +: 2] = st_r.restart;
			ADDR_CTRL:
			begin
				rd_word[WDEN_BIT]  = st_r.wden;
				rd_word[WDFLT_BIT] = st_r.wdflt;
			end
			ADDR_STAT:
				rd_word[4:0] = {st_r.wd_lat, st_r.oc_lat, wd_expired, st_r.oc_s2, st_r.sw_on};
			default:
				rd_hit = 1'b0;
		endcase
	end

	// Next state: sync, register writes, switch control, decoded outputs
	always_comb
	begin
		st_nxt = st_r;
		rearm  = 1'b0;

		// Overcurrent pin crosses into pclk through two flops
		st_nxt.oc_s1 = batt_overcurrent;
		st_nxt.oc_s2 = st_r.oc_s1;

		// Field writes; status and unmapped words ignore data
		if (wr_done)
		begin
			unique case (paddr)
				ADDR_BATT:
				begin
					st_nxt.cv   = pwdata[CV_LSB +: 6];
					st_nxt.vsys = pwdata[VSYS_LSB +: 2];
				end
				ADDR_SWCFG:
				begin
					st_nxt.wdclr  = pwdata[WDCLR_LSB +: 2];
					st_nxt.wdoff  = pwdata[WDOFF_BIT];
					st_nxt.keepon = pwdata[KEEPON_BIT];
					st_nxt.wdper  = pwdata[WDPER_BIT];
				end
				ADDR_RESTART:
					st_nxt.restart = pwdata[RESTART_LSB +: 2];
				ADDR_CTRL:
				begin
					st_nxt.wden  = pwdata[WDEN_BIT];
					st_nxt.wdflt = pwdata[WDFLT_BIT];
					rearm        = pwdata[REARM_BIT];
				end
				default:
				begin
				end
			endcase
		end

		// Only the exact kick code restarts, and only while enabled
		st_nxt.wd_clear = wr_done && (paddr == ADDR_SWCFG)
			&& (pwdata[WDCLR_LSB +: 2] == WDCLR_KICK) && st_r.wden;

		// Trips latch the switch off; a trip in the rearm cycle still wins
		st_nxt.oc_lat = (oc_tripped && !st_r.keepon) || (st_r.oc_lat && !rearm);
		st_nxt.wd_lat = (wd_expired && st_r.wdflt) || (st_r.wd_lat && !rearm);

		// The storage bit at WDOFF_BIT deliberately takes no part here
		st_nxt.sw_on = !(st_nxt.oc_lat || st_nxt.wd_lat);

		// Decoded settings follow the fields written this cycle
		st_nxt.cv_mv   = cbs_cv_mv(st_nxt.cv);
		st_nxt.vsys_mv = cbs_vsys_mv(st_nxt.vsys);
		st_nxt.rst_en  = (st_nxt.restart != RESTART_OFF);
		st_nxt.rst_mv  = st_nxt.rst_en
			? 13'(st_nxt.cv_mv - cbs_drop_mv(st_nxt.restart)) : 13'h000;

		// One wait state lets the answer come from flops
		st_nxt.pready  = psel && penable && !st_r.pready;
		st_nxt.pslverr = st_nxt.pready && !rd_hit;
		if (st_nxt.pready && !pwrite)
			st_nxt.prdata = rd_word;
	end

	// All state in one register; reset brings every field to default
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= TOP_RST;
		else
			st_r <= st_nxt;
	end

	// Persistence filter on the synchronised overcurrent level
	cbs_ocflt #(
		.LIMIT (OC_PERSIST_CYCLES)
	) u_ocflt (
		.pclk     (pclk),
		.presetn  (presetn),
		.oc_level (st_r.oc_s2),
		.tripped  (oc_tripped)
	);

	// Watchdog, kicked by the registered clear pulse
	cbs_wdog #(
		.LONG_CYC  (WD_LONG_CYCLES),
		.SHORT_CYC (WD_SHORT_CYCLES)
	) u_wdog (
		.pclk       (pclk),
		.presetn    (presetn),
		.enable     (st_r.wden),
		.period_sel (st_r.wdper),
		.restart    (st_r.wd_clear),
		.expired    (wd_expired)
	);

	// Outputs straight from the state flops
	assign prdata                   = st_r.prdata;
	assign pready                   = st_r.pready;
	assign pslverr                  = st_r.pslverr;
	assign charge_voltage_mv        = st_r.cv_mv;
	assign restart_threshold_mv     = st_r.rst_mv;
	assign restart_enable           = st_r.rst_en;
	assign system_min_voltage_sel   = st_r.vsys;
	assign system_min_voltage_mv    = st_r.vsys_mv;
	assign battery_isolation_switch = st_r.sw_on;
	assign watchdog_expired         = wd_expired;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	cv_floor_a: assert property (
		(st_r.cv <= 6'h08) |-> (charge_voltage_mv == 13'hDAC))
		else $error("low termination code not at floor");

	cv_saturate_a: assert property (
		(st_r.cv >= 6'h37) |-> (charge_voltage_mv == 13'h1158))
		else $error("high termination code not saturated");

	cv_first_step_a: assert property (
		(st_r.cv == 6'h09) |-> (charge_voltage_mv == 13'hDC0))
		else $error("first termination step wrong");

	reset_defaults_a: assert property (
		!$past(presetn) |-> (st_r.cv == 6'h2B) && (st_r.vsys == 2'h0)
			&& !st_r.keepon && (charge_voltage_mv == 13'h1068))
		else $error("fields not at default after reset");

	batt_write_a: assert property (
		wr_done && (paddr == ADDR_BATT) |=> (st_r.cv == $past(pwdata[5:0]))
			&& (charge_voltage_mv == cbs_cv_mv($past(pwdata[5:0]))))
		else $error("termination code write lost");

	vsys_decode_a: assert property (
		(system_min_voltage_sel == 2'h2) |-> (system_min_voltage_mv == 13'h10CC))
		else $error("system minimum decode wrong");

	kick_code_a: assert property (
		wr_done && (paddr == ADDR_SWCFG) && (pwdata[1:0] != 2'h1) |=> !st_r.wd_clear)
		else $error("watchdog cleared by a wrong code");

	kick_restart_a: assert property (
		wr_done && (paddr == ADDR_SWCFG) && (pwdata[1:0] == 2'h1) && st_r.wden
			|=> st_r.wd_clear ##1 !st_r.wd_clear)
		else $error("watchdog kick not a single pulse");

	oc_switch_off_a: assert property (
		oc_tripped && !st_r.keepon |=> !battery_isolation_switch)
		else $error("switch left on after overcurrent");

	keep_on_hold_a: assert property (
		st_r.keepon && !st_r.oc_lat && !st_r.wd_lat && !(wd_expired && st_r.wdflt)
			|=> battery_isolation_switch)
		else $error("switch dropped with keep-on set");

	storage_bit_a: assert property (
		battery_isolation_switch == !(st_r.oc_lat || st_r.wd_lat))
		else $error("switch depends on more than the trip latches");

	restart_drop_a: assert property (
		(st_r.restart == 2'h2) |-> restart_enable
			&& (restart_threshold_mv == 13'(charge_voltage_mv - 13'h0C8)))
		else $error("restart threshold not 200 mV below");

	restart_off_a: assert property (
		(st_r.restart == 2'h3) |-> !restart_enable)
		else $error("restart not disabled by code 3");

	apb_wait_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("APB answer not one wait state");

	// Switch latches, the pin synchroniser and the bus error path
	rearm_restores_a: assert property (
		wr_done && (paddr == ADDR_CTRL) && pwdata[REARM_BIT] && !oc_tripped
			&& !(wd_expired && st_r.wdflt) |=> battery_isolation_switch)
		else $error("switch not restored by rearm");

	keep_on_no_latch_a: assert property (
		st_r.keepon && !st_r.oc_lat |=> !st_r.oc_lat)
		else $error("overcurrent latched with keep-on set");

	oc_sync_delay_a: assert property (
		$past(presetn, 2) |-> (st_r.oc_s2 == $past(batt_overcurrent, 2)))
		else $error("overcurrent pin not two flops deep");

	unmapped_error_a: assert property (
		psel && penable && !pready && (paddr == 8'h00) |=> pready && pslverr)
		else $error("unmapped address answered without error");

	wd_fault_off_a: assert property (
		wd_expired && st_r.wdflt |=> !battery_isolation_switch)
		else $error("switch left on after watchdog fault");

endmodule : cbs_top

// File: bench/cbs_host.sv
// Purpose: APB host model standing in for software on the control bus.
// Assumes: Slave answers with pready; one transfer at a time.
// Notes:   Write data is inverted when idle so stale values are never trusted.
`timescale 1ns/100ps
module cbs_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Idle bus from time zero
	initial
	begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// Setup, then access held until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwdata  <= ~d;
	endtask : xfer
endmodule : cbs_host

// File: bench/cbs_top_bench.sv
// Purpose: Self-checking bench for the battery and switch config slice.
// Assumes: Short counts: persistence 20, watchdog long 200, short 80 cycles.
// Notes:   Outputs are sampled at rising edges, before that edge's updates.
`timescale 1ns/100ps
module cbs_top_bench;
	import cbs_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        oc;
	logic [12:0] cv_mv;
	logic [12:0] rs_mv;
	logic [12:0] vs_mv;
	logic        rs_en;
	logic [1:0]  vs_sel;
	logic        sw;
	logic        wd_exp;
	int          bad_count;
	int          compares;

	cbs_top #(.OC_PERSIST_CYCLES(22'h14), .WD_LONG_CYCLES(35'hC8), .WD_SHORT_CYCLES(35'h50))
	u_cbs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .batt_overcurrent(oc), .charge_voltage_mv(cv_mv),
		.restart_threshold_mv(rs_mv), .restart_enable(rs_en), .system_min_voltage_sel(vs_sel),
		.system_min_voltage_mv(vs_mv), .battery_isolation_switch(sw), .watchdog_expired(wd_exp));

	cbs_host u_cbs_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 200 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge pclk);
	endtask : step

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		u_cbs_host.xfer(1'b1, a, d, q, e);
		chk("pslverr", 32'h0, {31'h0, e});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		u_cbs_host.xfer(1'b0, a, 32'h0, q, e);
		chk("pslverr", 32'h0, {31'h0, e});
		chk("prdata", exp, q);
	endtask : rd

	// Reference decode of the termination code, in millivolts
	function automatic logic [12:0] ref_cv(input logic [5:0] c);
		if (c <= 6'h08)
			return 13'hDAC;
		if (c >= 6'h37)
			return 13'h1158;
		return 13'(13'hDAC + 13'h014 * (c - 6'h08));
	endfunction : ref_cv

	task automatic t_defaults;
		chk("cv_mv", 32'h1068, 32'(cv_mv));
		chk("vs_sel", 32'h0, 32'(vs_sel));
		chk("vs_mv", 32'hDAC, 32'(vs_mv));
		chk("rs_mv", 32'hFD2, 32'(rs_mv));
		chk("rs_en", 32'h1, 32'(rs_en));
		chk("switch", 32'h1, 32'(sw));
		chk("wd_exp", 32'h0, 32'(wd_exp));
		rd(ADDR_BATT, 32'h2B);
		rd(ADDR_SWCFG, 32'h0);
		rd(ADDR_RESTART, 32'h1);
		rd(ADDR_CTRL, 32'h0);
	endtask : t_defaults

	// Floor, first step, default, last step and saturation codes, all selectors
	task automatic t_volt;
		logic [5:0]  codes [9];
		logic [12:0] vsys [4];
		logic [7:0]  d;
		codes = '{6'h00, 6'h08, 6'h09, 6'h0A, 6'h2B, 6'h36, 6'h37, 6'h38, 6'h3F};
		vsys = '{13'hDAC, 13'hE74, 13'h10CC, 13'hDAC};
		for (int i = 0; i < 9; i++)
		begin
			d = {2'(i), codes[i]};
			wr(ADDR_BATT, {24'h0, d});
			step(2);
			chk("cv_mv", 32'(ref_cv(codes[i])), 32'(cv_mv));
			chk("vs_sel", 32'(i % 4), 32'(vs_sel));
			chk("vs_mv", 32'(vsys[i % 4]), 32'(vs_mv));
			rd(ADDR_BATT, {24'h0, d});
		end
	endtask : t_volt

	// Every restart code below the saturated 4440 mV setting
	task automatic t_restart;
		logic [12:0] drop [4];
		drop = '{13'h064, 13'h096, 13'h0C8, 13'h000};
		for (int r = 0; r < 4; r++)
		begin
			wr(ADDR_RESTART, 32'(r));
			step(2);
			chk("rs_en", 32'(r != 3), 32'(rs_en));
			chk("rs_mv", (r == 3) ? 32'h0 : 32'(13'h1158 - drop[r]), 32'(rs_mv));
		end
	endtask : t_restart

	// Storage bit, reserved bits and an unmapped address
	task automatic t_swcfg;
		logic [31:0] q;
		logic        e;
		wr(ADDR_SWCFG, 32'hFF);
		rd(ADDR_SWCFG, 32'h4F);
		wr(ADDR_SWCFG, 32'h04);
		step(30);
		chk("switch", 32'h1, 32'(sw));
		u_cbs_host.xfer(1'b0, 8'h00, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		wr(ADDR_SWCFG, 32'h0);
	endtask : t_swcfg

	// Broken burst, continuous burst, latch, rearm, then keep-on
	task automatic t_oc;
		oc <= 1'b1;
		step(15);
		oc <= 1'b0;
		step(2);
		oc <= 1'b1;
		step(21);
		chk("switch", 32'h1, 32'(sw));
		step(7);
		chk("switch", 32'h0, 32'(sw));
		oc <= 1'b0;
		step(5);
		chk("switch", 32'h0, 32'(sw));
		rd(ADDR_STAT, 32'h8);
		wr(ADDR_CTRL, 32'h4);
		step(2);
		chk("switch", 32'h1, 32'(sw));
		wr(ADDR_SWCFG, 32'h8);
		oc <= 1'b1;
		step(60);
		chk("switch", 32'h1, 32'(sw));
		oc <= 1'b0;
		wr(ADDR_SWCFG, 32'h0);
	endtask : t_oc

	// Long period, non-kick codes while expired, kick, short period, fault switch-off
	task automatic t_wdog;
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_SWCFG, 32'h1);
		step(180);
		chk("wd_exp", 32'h0, 32'(wd_exp));
		step(30);
		chk("wd_exp", 32'h1, 32'(wd_exp));
		for (int c = 0; c < 4; c++)
		begin
			wr(ADDR_SWCFG, 32'((c + 2) % 4));
			step(4);
			chk("wd_exp", 32'(c != 3), 32'(wd_exp));
		end
		wr(ADDR_SWCFG, 32'h41);
		step(65);
		chk("wd_exp", 32'h0, 32'(wd_exp));
		step(25);
		chk("wd_exp", 32'h1, 32'(wd_exp));
		wr(ADDR_CTRL, 32'h3);
		step(2);
		chk("switch", 32'h0, 32'(sw));
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_CTRL, 32'h4);
		step(2);
		chk("switch", 32'h1, 32'(sw));
	endtask : t_wdog

	// Reset in mid-run after every field but the watchdog enable was changed
	task automatic t_midreset;
		wr(ADDR_BATT, 32'hFF);
		wr(ADDR_SWCFG, 32'h4F);
		wr(ADDR_RESTART, 32'h3);
		wr(ADDR_CTRL, 32'h2);
		presetn <= 1'b0;
		step(3);
		presetn <= 1'b1;
		step(2);
		t_defaults();
	endtask : t_midreset

	task automatic stop_test;
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	// Main sequence
	initial
	begin
		presetn = 1'b0;
		oc = 1'b0;
		bad_count = 0;
		compares = 0;
		step(10);
		presetn <= 1'b1;
		step(1);
		t_defaults();
		t_volt();
		t_restart();
		t_swcfg();
		t_oc();
		t_wdog();
		t_midreset();
		stop_test();
	end

	// Run needs about 700 cycles; a hang is cut short well beyond that
	initial
	begin
		step(20000);
		bad_count++;
		stop_test();
	end
endmodule : cbs_top_bench
